// >>> verilog/dsd_params.svh
// constants of the demo status and display controller: offsets, fields, resets, timing
`ifndef DSD_PARAMS_SVH
`define DSD_PARAMS_SVH

`define DSD_CLK_MHZ 100
`define DSD_DEBOUNCE_US 10000
`define DSD_DEBOUNCE_CYCLES (`DSD_DEBOUNCE_US * `DSD_CLK_MHZ)
`define DSD_SECOND_US 1000000
`define DSD_SECOND_CYCLES (`DSD_SECOND_US * `DSD_CLK_MHZ)
`define DSD_XCVR_RESET_CYCLES 16

`define DSD_REG_CTRL 6'h00
`define DSD_REG_STATUS 6'h04
`define DSD_REG_SETTINGS 6'h08
`define DSD_REG_CNT_FIRST 6'h0C
`define DSD_REG_CNT_LAST 6'h1C
`define DSD_REG_TIME 6'h20

`define DSD_CTRL_ERR_CLEAR 0
`define DSD_CTRL_PAGE_ADV 1

`define DSD_CNT_MAX 10'h03E7
`define DSD_MIN_MAX 6'h3B
`define DSD_HOUR_MAX 4'h9
`define DSD_SYNC_NORMAL 8'h47
`define DSD_SYNC_INVERTED 8'hB8
`define DSD_PAGE_RESET 2'h0
`define DSD_READ_UNMAPPED 32'h0000_0000

`define DSD_LEN_0 8'hBC
`define DSD_LEN_1 8'hCC
`define DSD_LEN_2 8'hBB
`define DSD_LEN_3 8'hCB
`define DSD_LEN_4 8'hBD
`define DSD_LEN_5 8'hCD
`define DSD_LEN_6 8'hAF
`define DSD_LEN_7 8'hDC

`endif

// >>> verilog/dsd_pkg.sv
// types of the demo status and display controller
package dsd_pkg;

  typedef enum logic [2:0] {
    DSD_LOCK_UNKNOWN = 3'b001,
    DSD_LOCK_NO_SIGNAL = 3'b010,
    DSD_LOCK_LOCKED = 3'b100
  } dsd_lock_t;

  typedef enum logic [1:0] {
    DSD_BUS_IDLE = 2'b01,
    DSD_BUS_ANSWER = 2'b10
  } dsd_bus_t;

  localparam int DSD_NUM_COUNTERS = 5;
  localparam int DSD_NUM_BUTTONS = 3;

endpackage : dsd_pkg

// >>> verilog/dsd_status_display.sv
// demo status, operator-button and display-page controller with an avalon-mm register slave
//
// Summary of operation
// RQ1 - Master-reset button press resets all demo logic and the transceiver.
// RQ2 - Error-reset press clears compare, fifo-full, runt and giant counters.
// RQ3 - Error-reset press also returns elapsed time to 0:00.
// RQ4 - Each page-advance press steps to the next page, wrapping around.
// RQ5 - After reset the display shows page zero.
// RQ6 - Display is two lines of sixteen characters with four pages.
// RQ7 - Transmit clock select from two switches: 20, 27 out, 40, 27 in MHz.
// RQ8 - Receive clock select uses the same encoding.
// RQ9 - Sync switch picks 47 hex at 0, B8 hex at 1.
// RQ10 - Three-bit length select maps to 188,204,187,203,189,205,175,220 bytes.
// RQ11 - Fifo-full leds are lit while their flag is high.
// RQ12 - Runt and giant leds light on undersized or oversized packets.
// RQ13 - Compare-error led lights on a data mismatch.
// RQ14 - Packet-length led off for 188, lit for 204.
// RQ15 - Sync-byte led off for 47 hex, lit for B8 hex.
// RQ16 - Not-locked led is inverse of locked; another led shows locked directly.
// RQ17 - Lock text: Locked, No Signal on loss, Unknown when all low.
// RQ18 - Error counters saturate at 999.
// RQ19 - Elapsed time stops at 9 hours 59 minutes.
// RQ20 - Page zero shows clock, lengths, sync bytes and lock text.
// RQ21 - Page one shows the four measured clock frequencies.
// RQ22 - Pages two and three show selected error counts plus elapsed time.
// RQ23 - Buttons are synchronised, debounced, one pulse per press.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "dsd_params.svh"

module dsd_status_display #(
  parameter int DEBOUNCE_CYCLES = `DSD_DEBOUNCE_CYCLES,
  parameter int SECOND_CYCLES = `DSD_SECOND_CYCLES,
  parameter int PAGE_COUNT = 4
) (
  input wire logic CLK_SYS, // 100 MHz system clock
  input wire logic RESETN, // asynchronous reset, active low
  input wire logic MASTER_RESET_BUTTON, // high while pressed
  input wire logic ERROR_RESET_BUTTON, // high while pressed
  input wire logic PAGE_ADVANCE_BUTTON, // high while pressed
  input wire logic [3:0] CLOCK_SELECT_SWITCH_BANK, // dip bank, bit 3 = switch 4
  input wire logic [3:0] TRAFFIC_SETTING_SWITCH_BANK, // dip bank, bit 3 = switch 4
  input wire logic TX_FIFO_FULL, // transmit fifo full flag
  input wire logic RX_FIFO_FULL, // receive fifo full flag
  input wire logic RX_RUNT, // undersized packet received
  input wire logic RX_GIANT, // oversized packet received
  input wire logic CMP_ERR, // data comparison mismatch
  input wire logic RX_PKT_SIZE, // 0 = 188, 1 = 204
  input wire logic RX_SYNC_BYTE, // 0 = 47h, 1 = B8h
  input wire logic RX_LOCKED, // receiver locked to stream
  input wire logic RECOVERY_LOCK_LOST, // clock recovery lost lock
  input wire logic INPUT_SIGNAL_ABSENT, // no signal at serial input
  input wire logic TX_PLL_LOCK_LOST, // transmit pll unlocked
  input wire logic [5:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // stall
  output logic XCVR_RESET, // reset to transceiver and coding sublayer
  output logic [1:0] TX_CLK_SEL, // transmit user clock select
  output logic [1:0] RX_CLK_SEL, // receive user clock select
  output logic [7:0] TX_SYNC_CHAR, // transmit sync byte
  output logic [7:0] TX_PKT_LEN, // transmit packet length in bytes
  output logic LED_TX_FFULL, // lit = 1
  output logic LED_RX_FFULL, // lit = 1
  output logic LED_RUNT, // lit = 1
  output logic LED_GIANT, // lit = 1
  output logic LED_RX_LOCK_LOST, // lit = 1
  output logic LED_CMP_ERR, // lit = 1
  output logic LED_PKT_SIZE, // lit = 204-byte packets
  output logic LED_SYNC_BYTE, // lit = B8h sync
  output logic LED_TX_LOCK_LOST, // lit = 1
  output logic LED_SIGNAL_ABSENT, // lit = 1
  output logic LED_RX_NO_LOCK, // lit when not locked
  output logic LED_RX_LOCKED, // lit when locked
  output logic [1:0] DISP_PAGE, // page on the 2x16 display
  output dsd_pkg::dsd_lock_t DISP_LOCK, // lock text one-hot
  output logic [9:0] DISP_COUNT_A, // first count of the page
  output logic [9:0] DISP_COUNT_B, // second count of the page
  output logic [9:0] DISP_COUNT_C, // third count of the page
  output logic [3:0] DISP_HOURS, // elapsed hours
  output logic [5:0] DISP_MINUTES // elapsed minutes
);
  import dsd_pkg::*;

  localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int SEC_W = $clog2(SECOND_CYCLES + 1);

  initial begin
    if (PAGE_COUNT != 4) $error("PAGE_COUNT must be 4");
    if (DEBOUNCE_CYCLES < 2) $error("DEBOUNCE_CYCLES must be at least 2");
    if (SECOND_CYCLES < 2) $error("SECOND_CYCLES must be at least 2");
  end

  // ---------------- buttons ----------------
  logic [DSD_NUM_BUTTONS-1:0] btn_in;
  logic [DSD_NUM_BUTTONS-1:0] btn_meta_reg;
  logic [DSD_NUM_BUTTONS-1:0] btn_sync_reg;
  logic [DSD_NUM_BUTTONS-1:0] btn_stable_reg;
  logic [DSD_NUM_BUTTONS-1:0] btn_press_reg;
  logic [DB_W-1:0] db_cnt_reg [DSD_NUM_BUTTONS];

  assign btn_in = {PAGE_ADVANCE_BUTTON, ERROR_RESET_BUTTON, MASTER_RESET_BUTTON};

  // a press must hold steady for the whole debounce time before it counts
  genvar gb;
  generate
    for (gb = 0; gb < DSD_NUM_BUTTONS; gb++) begin : g_btn
      wire differs = btn_sync_reg[gb] != btn_stable_reg[gb];
      wire settled = differs && (db_cnt_reg[gb] == DB_W'(DEBOUNCE_CYCLES - 1));
      always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
          btn_meta_reg[gb] <= 1'b0;
          btn_sync_reg[gb] <= 1'b0;
          btn_stable_reg[gb] <= 1'b0;
          btn_press_reg[gb] <= 1'b0;
          db_cnt_reg[gb] <= '0;
        end else begin
          btn_meta_reg[gb] <= btn_in[gb];
          btn_sync_reg[gb] <= btn_meta_reg[gb]; // [RQ23]
          btn_press_reg[gb] <= settled && btn_sync_reg[gb]; // [RQ23]
          if (settled) btn_stable_reg[gb] <= btn_sync_reg[gb];
          db_cnt_reg[gb] <= (differs && !settled) ? db_cnt_reg[gb] + DB_W'(1) : '0;
        end
      end
    end
  endgenerate

  // ---------------- bus slave ----------------
  dsd_bus_t bus_state_reg;
  dsd_bus_t bus_state_next;
  logic [31:0] readdata_reg;
  wire bus_req = AVS_READ || AVS_WRITE;
  wire bus_commit = bus_state_reg == DSD_BUS_ANSWER;
  // only byte lane 0 carries the control bits; a write without it changes nothing
  wire wr_ctrl = bus_commit && AVS_WRITE && AVS_BYTEENABLE[0] && {AVS_ADDRESS[5:2], 2'b00} == `DSD_REG_CTRL;
  wire sw_err_clear = wr_ctrl && AVS_WRITEDATA[`DSD_CTRL_ERR_CLEAR];
  wire sw_page_adv = wr_ctrl && AVS_WRITEDATA[`DSD_CTRL_PAGE_ADV];

  // answer one edge after the request is seen; the write lands on that edge
  always_comb begin
    bus_state_next = DSD_BUS_IDLE;
    unique case (bus_state_reg)
      DSD_BUS_IDLE: bus_state_next = bus_req ? DSD_BUS_ANSWER : DSD_BUS_IDLE;
      DSD_BUS_ANSWER: bus_state_next = DSD_BUS_IDLE;
      default: bus_state_next = DSD_BUS_IDLE;
    endcase
  end

  assign AVS_WAITREQUEST = bus_req && !bus_commit;
  assign AVS_READDATA = readdata_reg;

  // ---------------- resets and clears ----------------
  logic [4:0] xcvr_cnt_reg;
  wire soft_clr = btn_press_reg[0]; // [RQ1]
  wire err_clr = soft_clr || btn_press_reg[1] || sw_err_clear; // [RQ2]
  wire page_adv = btn_press_reg[2] || sw_page_adv;

  // the transceiver needs more than one cycle of reset, so the pulse is stretched
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      xcvr_cnt_reg <= 5'h00;
      XCVR_RESET <= 1'b1;
    end else begin
      xcvr_cnt_reg <= soft_clr ? 5'(`DSD_XCVR_RESET_CYCLES) : (xcvr_cnt_reg != 5'h00 ? xcvr_cnt_reg - 5'h01 : 5'h00);
      XCVR_RESET <= soft_clr || xcvr_cnt_reg > 5'h01; // [RQ1]
    end
  end

  // ---------------- error counters ----------------
  logic [DSD_NUM_COUNTERS-1:0] ev_in;
  logic [DSD_NUM_COUNTERS-1:0] ev_prev_reg;
  logic [9:0] count_reg [DSD_NUM_COUNTERS];

  // index: 0 tx fifo full, 1 rx fifo full, 2 compare, 3 runt, 4 giant
  assign ev_in = {RX_GIANT, RX_RUNT, CMP_ERR, RX_FIFO_FULL, TX_FIFO_FULL};

  genvar gc;
  generate
    for (gc = 0; gc < DSD_NUM_COUNTERS; gc++) begin : g_cnt
      wire rise = ev_in[gc] && !ev_prev_reg[gc];
      wire at_max = count_reg[gc] == `DSD_CNT_MAX;
      // an event in the clearing cycle survives as a count of one
      wire [9:0] count_next = err_clr ? {9'h000, rise} : ((rise && !at_max) ? count_reg[gc] + 10'h001 : count_reg[gc]);
      always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
          ev_prev_reg[gc] <= 1'b0;
          count_reg[gc] <= 10'h000;
        end else begin
          ev_prev_reg[gc] <= ev_in[gc];
          count_reg[gc] <= count_next; // [RQ2] [RQ18]
        end
      end
    end
  endgenerate

  // ---------------- elapsed time ----------------
  logic [SEC_W-1:0] tick_reg;
  logic [5:0] sec_reg;
  logic [5:0] min_reg;
  logic [3:0] hour_reg;
  wire time_full = hour_reg == `DSD_HOUR_MAX && min_reg == `DSD_MIN_MAX;
  wire sec_tick = tick_reg == SEC_W'(SECOND_CYCLES - 1);
  wire min_tick = sec_tick && sec_reg == 6'h3B;
  wire hour_tick = min_tick && min_reg == `DSD_MIN_MAX;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      tick_reg <= '0;
      sec_reg <= 6'h00;
      min_reg <= 6'h00;
      hour_reg <= 4'h0;
    end else if (err_clr) begin
      tick_reg <= '0; // [RQ3]
      sec_reg <= 6'h00;
      min_reg <= 6'h00;
      hour_reg <= 4'h0;
    end else if (!time_full) begin // [RQ19]
      tick_reg <= sec_tick ? '0 : tick_reg + SEC_W'(1);
      if (sec_tick) sec_reg <= min_tick ? 6'h00 : sec_reg + 6'h01;
      if (min_tick) min_reg <= hour_tick ? 6'h00 : min_reg + 6'h01;
      if (hour_tick) hour_reg <= hour_reg + 4'h1;
    end
  end

  // ---------------- display page and switch decode ----------------
  logic [1:0] page_reg;
  dsd_lock_t lock_next;
  logic [7:0] len_next;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) page_reg <= `DSD_PAGE_RESET; // [RQ5]
    else if (soft_clr) page_reg <= `DSD_PAGE_RESET; // [RQ5]
    else if (page_adv) page_reg <= page_reg + 2'h1; // [RQ4] [RQ6]
  end

  assign lock_next = RX_LOCKED ? DSD_LOCK_LOCKED :
                     (INPUT_SIGNAL_ABSENT || RECOVERY_LOCK_LOST) ? DSD_LOCK_NO_SIGNAL : DSD_LOCK_UNKNOWN; // [RQ17]
  assign len_next = TRAFFIC_SETTING_SWITCH_BANK[2] ?
                    (TRAFFIC_SETTING_SWITCH_BANK[1] ? (TRAFFIC_SETTING_SWITCH_BANK[0] ? `DSD_LEN_7 : `DSD_LEN_6) :
                                                      (TRAFFIC_SETTING_SWITCH_BANK[0] ? `DSD_LEN_5 : `DSD_LEN_4)) :
                    (TRAFFIC_SETTING_SWITCH_BANK[1] ? (TRAFFIC_SETTING_SWITCH_BANK[0] ? `DSD_LEN_3 : `DSD_LEN_2) :
                                                      (TRAFFIC_SETTING_SWITCH_BANK[0] ? `DSD_LEN_1 : `DSD_LEN_0)); // [RQ10]

  // page 0 takes clock, length, sync and lock fields from the outputs below;
  // the frequency figures of page 1 come from the measurement counters outside
  wire show_counts = page_reg[1]; // [RQ20] [RQ21] [RQ22]
  wire [9:0] count_a_next = !show_counts ? 10'h000 : (page_reg[0] ? count_reg[3] : count_reg[0]);
  wire [9:0] count_b_next = !show_counts ? 10'h000 : (page_reg[0] ? count_reg[4] : count_reg[1]);
  wire [9:0] count_c_next = show_counts ? count_reg[2] : 10'h000;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      TX_CLK_SEL <= 2'h0;
      RX_CLK_SEL <= 2'h0;
      TX_SYNC_CHAR <= `DSD_SYNC_NORMAL;
      TX_PKT_LEN <= `DSD_LEN_0;
      DISP_LOCK <= DSD_LOCK_UNKNOWN;
      DISP_COUNT_A <= 10'h000;
      DISP_COUNT_B <= 10'h000;
      DISP_COUNT_C <= 10'h000;
    end else begin
      TX_CLK_SEL <= CLOCK_SELECT_SWITCH_BANK[3:2]; // [RQ7]
      RX_CLK_SEL <= CLOCK_SELECT_SWITCH_BANK[1:0]; // [RQ8]
      TX_SYNC_CHAR <= TRAFFIC_SETTING_SWITCH_BANK[3] ? `DSD_SYNC_INVERTED : `DSD_SYNC_NORMAL; // [RQ9]
      TX_PKT_LEN <= len_next; // [RQ10]
      DISP_LOCK <= lock_next; // [RQ17]
      DISP_COUNT_A <= count_a_next; // [RQ22]
      DISP_COUNT_B <= count_b_next; // [RQ22]
      DISP_COUNT_C <= count_c_next; // [RQ22]
    end
  end

  assign DISP_PAGE = page_reg;
  assign DISP_HOURS = hour_reg;
  assign DISP_MINUTES = min_reg;

  // ---------------- leds ----------------
  // one cycle behind the flags; invisible to the eye, keeps the pins glitch free
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      {LED_TX_FFULL, LED_RX_FFULL, LED_RUNT, LED_GIANT, LED_CMP_ERR} <= 5'h00;
      {LED_PKT_SIZE, LED_SYNC_BYTE, LED_RX_LOCK_LOST, LED_TX_LOCK_LOST, LED_SIGNAL_ABSENT} <= 5'h00;
      LED_RX_LOCKED <= 1'b0;
      LED_RX_NO_LOCK <= 1'b1;
    end else begin
      LED_TX_FFULL <= TX_FIFO_FULL; // [RQ11]
      LED_RX_FFULL <= RX_FIFO_FULL; // [RQ11]
      LED_RUNT <= RX_RUNT; // [RQ12]
      LED_GIANT <= RX_GIANT; // [RQ12]
      LED_CMP_ERR <= CMP_ERR; // [RQ13]
      LED_PKT_SIZE <= RX_PKT_SIZE; // [RQ14]
      LED_SYNC_BYTE <= RX_SYNC_BYTE; // [RQ15]
      LED_RX_LOCK_LOST <= RECOVERY_LOCK_LOST;
      LED_TX_LOCK_LOST <= TX_PLL_LOCK_LOST;
      LED_SIGNAL_ABSENT <= INPUT_SIGNAL_ABSENT;
      LED_RX_LOCKED <= RX_LOCKED; // [RQ16]
      LED_RX_NO_LOCK <= !RX_LOCKED; // [RQ16]
    end
  end

  // ---------------- register read ----------------
  wire [5:0] addr_w = {AVS_ADDRESS[5:2], 2'b00};
  wire is_cnt = addr_w >= `DSD_REG_CNT_FIRST && addr_w <= `DSD_REG_CNT_LAST;
  wire [5:0] cnt_off = addr_w - `DSD_REG_CNT_FIRST;
  wire [2:0] cnt_idx = cnt_off[4:2];
  wire [31:0] status_word = {16'h0000, LED_RX_LOCKED, LED_TX_LOCK_LOST, LED_SIGNAL_ABSENT, LED_RX_LOCK_LOST,
                             LED_SYNC_BYTE, LED_PKT_SIZE, LED_CMP_ERR, LED_GIANT, LED_RUNT, LED_RX_FFULL,
                             LED_TX_FFULL, DISP_LOCK, page_reg};
  wire [31:0] settings_word = {12'h000, TX_PKT_LEN, TX_SYNC_CHAR, RX_CLK_SEL, TX_CLK_SEL};
  wire [31:0] time_word = {20'h0_0000, hour_reg, 2'b00, min_reg};
  wire [31:0] read_word = addr_w == `DSD_REG_STATUS ? status_word :
                          addr_w == `DSD_REG_SETTINGS ? settings_word :
                          addr_w == `DSD_REG_TIME ? time_word :
                          is_cnt ? {22'h00_0000, count_reg[cnt_idx]} : `DSD_READ_UNMAPPED;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      bus_state_reg <= DSD_BUS_IDLE;
      readdata_reg <= 32'h0000_0000;
    end else begin
      bus_state_reg <= bus_state_next;
      if (AVS_READ && bus_state_reg == DSD_BUS_IDLE) readdata_reg <= read_word;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  press_single_a: assert property (btn_press_reg[2] |=> !btn_press_reg[2]) // [RQ23]
    else $error("page press lasted more than one cycle");
  page_wrap_a: assert property (page_reg == 2'h3 && page_adv && !soft_clr |=> page_reg == 2'h0) // [RQ4]
    else $error("page did not wrap from three to zero");
  page_reset_a: assert property (soft_clr |=> page_reg == 2'h0 && XCVR_RESET) // [RQ5]
    else $error("master press did not return page zero and reset transceiver");
  xcvr_hold_a: assert property (soft_clr |=> XCVR_RESET [*8]) // [RQ1]
    else $error("transceiver reset not held");
  err_clear_a: assert property (btn_press_reg[1] && !ev_in[2] |=> count_reg[2] == 10'h000) // [RQ2]
    else $error("compare count not cleared");
  count_sat_a: assert property (count_reg[0] == `DSD_CNT_MAX && !err_clr |=> count_reg[0] == `DSD_CNT_MAX) // [RQ18]
    else $error("counter passed saturation");
  time_clear_a: assert property (btn_press_reg[1] |=> hour_reg == 4'h0 && min_reg == 6'h00) // [RQ3]
    else $error("elapsed time not cleared");
  time_stop_a: assert property (time_full && !err_clr |=> $stable(min_reg) && $stable(hour_reg)) // [RQ19]
    else $error("elapsed time advanced past the limit");
  len_decode_a: assert property (TRAFFIC_SETTING_SWITCH_BANK[2:0] == 3'b110 |=> TX_PKT_LEN == `DSD_LEN_6) // [RQ10]
    else $error("length select six not decoded");
  clk_sel_a: assert property (##1 TX_CLK_SEL == $past(CLOCK_SELECT_SWITCH_BANK[3:2])) // [RQ7]
    else $error("transmit clock select wrong");
  lock_text_a: assert property (!RX_LOCKED && INPUT_SIGNAL_ABSENT |=> DISP_LOCK == DSD_LOCK_NO_SIGNAL) // [RQ17]
    else $error("lock text not no-signal");
  lock_leds_a: assert property (LED_RX_NO_LOCK == !LED_RX_LOCKED) // [RQ16]
    else $error("lock leds not complementary");
  bus_answer_a: assert property (bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer later than one cycle");
  // one flag of the fifo-full and of the runt/giant led pairs is watched here; the others share the same copy register
  rx_clk_sel_a: assert property (##1 RX_CLK_SEL == $past(CLOCK_SELECT_SWITCH_BANK[1:0])) // [RQ8]
    else $error("receive clock select wrong");
  sync_char_a: assert property (TRAFFIC_SETTING_SWITCH_BANK[3] |=> TX_SYNC_CHAR == `DSD_SYNC_INVERTED) // [RQ9]
    else $error("inverted sync byte not selected");
  ffull_led_a: assert property (TX_FIFO_FULL |=> LED_TX_FFULL) // [RQ11]
    else $error("transmit fifo full led not lit");
  runt_led_a: assert property (RX_RUNT |=> LED_RUNT) // [RQ12]
    else $error("runt led not lit");

  page_wrap_c: cover property (page_reg == 2'h3 ##1 page_reg == 2'h0);
  count_sat_c: cover property (count_reg[2] == `DSD_CNT_MAX);
  bus_read_c: cover property (AVS_READ && !AVS_WAITREQUEST);
  time_full_c: cover property (time_full);
  xcvr_done_c: cover property (XCVR_RESET ##1 !XCVR_RESET);

endmodule : dsd_status_display

// >>> tb/dsd_panel_model.sv
// operator panel model: momentary pushbuttons held for a fixed press time
`timescale 1ns/1ps
module dsd_panel_model #(
  parameter int HOLD = 10
) (
  input wire logic clk, // system clock
  input wire logic [2:0] press, // one-cycle request per button
  output logic [2:0] button // high while pressed
);
  int cnt_reg [3] = '{0, 0, 0};
  always_ff @(posedge clk) begin
    for (int b = 0; b < 3; b++) begin
      if (press[b]) cnt_reg[b] <= HOLD;
      else if (cnt_reg[b] > 0) cnt_reg[b] <= cnt_reg[b] - 1;
    end
  end
  // held past the debounce time so each request is one clean momentary press
  always_comb for (int b = 0; b < 3; b++) button[b] = (cnt_reg[b] > 0);
endmodule : dsd_panel_model

// >>> tb/dsd_status_display_tb.sv
// self-checking bench of the demo status and display controller
`timescale 1ns/1ps
`include "dsd_params.svh"
module dsd_status_display_tb;
  import dsd_pkg::*;
  logic CLK_SYS = 0;
  logic RESETN = 0;
  logic [2:0] press = '0;
  logic [2:0] btn;
  logic [3:0] csw = '0;
  logic [3:0] tsw = '0;
  logic [4:0] ev = '0; // tff, rff, runt, giant, cmp
  logic [5:0] lv = '0; // pkt, sync, locked, lol, los, pll
  logic [5:0] adr = '0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wait_r, xcvr;
  logic [1:0] tsel, rsel, page;
  logic [7:0] sync, plen;
  logic [11:0] leds;
  dsd_lock_t lock;
  logic [9:0] ca, cb, cc;
  logic [3:0] hrs;
  logic [5:0] mins;
  logic [7:0] len_tab [8] = '{`DSD_LEN_0, `DSD_LEN_1, `DSD_LEN_2, `DSD_LEN_3,
    `DSD_LEN_4, `DSD_LEN_5, `DSD_LEN_6, `DSD_LEN_7};
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int xhigh = 0;
  int x0;

  dsd_panel_model #(.HOLD(10)) dsd_panel_model_inst (.clk(CLK_SYS), .press(press), .button(btn));

  dsd_status_display #(.DEBOUNCE_CYCLES(4), .SECOND_CYCLES(2), .PAGE_COUNT(4)) dsd_status_display_inst (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .MASTER_RESET_BUTTON(btn[0]), .ERROR_RESET_BUTTON(btn[1]),
    .PAGE_ADVANCE_BUTTON(btn[2]), .CLOCK_SELECT_SWITCH_BANK(csw), .TRAFFIC_SETTING_SWITCH_BANK(tsw),
    .TX_FIFO_FULL(ev[4]), .RX_FIFO_FULL(ev[3]), .RX_RUNT(ev[2]), .RX_GIANT(ev[1]), .CMP_ERR(ev[0]),
    .RX_PKT_SIZE(lv[5]), .RX_SYNC_BYTE(lv[4]), .RX_LOCKED(lv[3]), .RECOVERY_LOCK_LOST(lv[2]),
    .INPUT_SIGNAL_ABSENT(lv[1]), .TX_PLL_LOCK_LOST(lv[0]), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_r), .XCVR_RESET(xcvr), .TX_CLK_SEL(tsel), .RX_CLK_SEL(rsel),
    .TX_SYNC_CHAR(sync), .TX_PKT_LEN(plen), .LED_TX_FFULL(leds[11]), .LED_RX_FFULL(leds[10]),
    .LED_RUNT(leds[9]), .LED_GIANT(leds[8]), .LED_RX_LOCK_LOST(leds[7]), .LED_CMP_ERR(leds[6]),
    .LED_PKT_SIZE(leds[5]), .LED_SYNC_BYTE(leds[4]), .LED_TX_LOCK_LOST(leds[3]),
    .LED_SIGNAL_ABSENT(leds[2]), .LED_RX_NO_LOCK(leds[1]), .LED_RX_LOCKED(leds[0]),
    .DISP_PAGE(page), .DISP_LOCK(lock), .DISP_COUNT_A(ca), .DISP_COUNT_B(cb), .DISP_COUNT_C(cc),
    .DISP_HOURS(hrs), .DISP_MINUTES(mins));

  always #5 CLK_SYS = ~CLK_SYS;

  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    xhigh <= xhigh + int'(xcvr);
    if (cyc == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // avalon master: hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge CLK_SYS); while (wait_r);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge CLK_SYS);
  endtask : bus

  task automatic push(input int b);
    @(posedge CLK_SYS);
    press[b] <= 1'b1;
    @(posedge CLK_SYS);
    press[b] <= 1'b0;
    repeat (30) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask : push

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge CLK_SYS);
      ev <= 5'h1F;
      @(posedge CLK_SYS);
      ev <= 5'h00;
    end
  endtask : pulse

  task automatic settle;
    repeat (3) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask : settle

  task automatic read_counts(input logic [31:0] exp);
    for (int a = 0; a < 5; a++) begin
      bus(1'b0, `DSD_REG_CNT_FIRST + 6'(4 * a), 32'h0000_0000);
      check(q, exp);
    end
  endtask : read_counts

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    @(negedge CLK_SYS);
    check(32'(page), 32'(`DSD_PAGE_RESET));
    for (int i = 0; i < 16; i++) begin
      @(posedge CLK_SYS);
      csw <= 4'(i);
      tsw <= 4'(i);
      settle();
      check(32'(tsel), 32'(i[3:2]));
      check(32'(rsel), 32'(i[1:0]));
      check(32'(sync), i[3] ? 32'h0000_00B8 : 32'h0000_0047);
      check(32'(plen), 32'(len_tab[i[2:0]]));
    end
    bus(1'b0, `DSD_REG_SETTINGS, 32'h0000_0000);
    check(q, {12'h000, `DSD_LEN_7, `DSD_SYNC_INVERTED, 4'hF});
    // every led and every lock-text case; the flag edges also load the counters
    for (int i = 0; i < 16; i++) begin
      @(posedge CLK_SYS);
      ev <= {i[0], i[1], i[2], i[3], ~i[0]};
      lv <= {i[1] ^ i[0], i[2], i[0], i[1], i[2] & i[3], i[3]};
      settle();
      check(32'(leds), 32'({ev[4:1], lv[2], ev[0], lv[5:4], lv[0], lv[1], ~lv[3], lv[3]}));
      check(32'(lock), lv[3] ? 32'h4 : (lv[2] | lv[1]) ? 32'h2 : 32'h1);
    end
    @(posedge CLK_SYS);
    ev <= 5'h00;
    for (int p = 1; p <= 4; p++) begin
      push(2);
      check(32'(page), 32'(p % 4));
    end
    bus(1'b1, `DSD_REG_CTRL, 32'h0000_0002);
    check(32'(page), 32'h1);
    push(1);
    read_counts(32'h0000_0000);
    bus(1'b0, `DSD_REG_TIME, 32'h0000_0000);
    check(q, 32'h0000_0000);
    check(32'({hrs, mins}), 32'h0000_0000);
    pulse(3);
    for (int p = 2; p < 4; p++) begin
      bus(1'b1, `DSD_REG_CTRL, 32'h0000_0002);
      settle();
      check(32'({page, ca, cb, cc}), 32'({2'(p), 10'd3, 10'd3, 10'd3}));
    end
    pulse(1000);
    read_counts(32'h0000_03E7);
    bus(1'b1, `DSD_REG_CTRL, 32'h0000_0001);
    read_counts(32'h0000_0000);
    repeat (400) @(posedge CLK_SYS);
    bus(1'b0, `DSD_REG_TIME, 32'h0000_0000);
    check(q, 32'h0000_0003);
    check(32'({hrs, mins}), 32'h0000_0003);
    bus(1'b0, 6'h3C, 32'h0000_0000);
    check(q, `DSD_READ_UNMAPPED);
    pulse(2);
    x0 = xhigh;
    push(0);
    check(32'(xhigh - x0), 32'(`DSD_XCVR_RESET_CYCLES));
    check(32'(page), 32'h0);
    read_counts(32'h0000_0000);
    bus(1'b0, `DSD_REG_STATUS, 32'h0000_0000);
    check(q, 32'h0000_F810);
    // about ten hours of shortened seconds: the elapsed time must stop at 9:59
    repeat (72000) @(posedge CLK_SYS);
    bus(1'b0, `DSD_REG_TIME, 32'h0000_0000);
    check(q, 32'h0000_093B);
    check(32'({hrs, mins}), 32'({`DSD_HOUR_MAX, `DSD_MIN_MAX}));
    tally_and_finish();
  end
endmodule : dsd_status_display_tb
